// ===== hw/opm_pkg.sv
// constants and register map of the option port read mux
package opm_pkg;
   // ==========================================================
   // register byte offsets on the axi4-lite slave
   localparam logic [7:0] OPM_DIR_OFS = 8'h04;
   localparam logic [7:0] OPM_DATA_OFS = 8'h10;
   localparam logic [7:0] OPM_OPT_OFS = 8'h20;
   localparam logic [7:0] OPM_WAKE_OFS = 8'h24;
   localparam logic [7:0] OPM_WSTAT_OFS = 8'h28;
   // ==========================================================
   // widths and reset values
   localparam int OPM_PW = 4;
   localparam logic [3:0] OPM_DIR_RST = 4'h0;
   localparam logic [3:0] OPM_DATA_RST = 4'h0;
   localparam logic [3:0] OPM_ZERO4 = 4'h0;
   // ==========================================================
   // option field positions in the option readback word
   localparam int OPM_OPT_OPAMP = 0;
   localparam int OPM_OPT_CMP1 = 1;
   localparam int OPM_OPT_CMP2 = 2;
   localparam int OPM_OPT_BIT1_READ_ZERO_OPTION = 3;
   localparam int OPM_OPT_BIT3_READ_ZERO_OPTION = 4;
   localparam int OPM_OPT_DAC = 5;
   localparam int OPM_OPT_MODE = 8;
   // wake word lanes: a, b, d, e
   localparam int OPM_WK_A = 0;
   localparam int OPM_WK_B = 4;
   localparam int OPM_WK_D = 8;
   localparam int OPM_WK_E = 12;
   localparam int OPM_WK_PWM = 16;
   // axi responses
   localparam logic [1:0] OPM_RESP_OKAY = 2'h0;
   localparam logic [1:0] OPM_RESP_SLVERR = 2'h2;
   // ==========================================================
   // port structure selected by options
   typedef enum logic [4:0] {
      OPM_IO = 5'h01,
      OPM_OPAMP = 5'h02,
      OPM_CMP = 5'h04,
      OPM_CMPOP = 5'h08,
      OPM_BAD = 5'h10
   } opm_mode_t;
endpackage

// ===== hw/opm_sync2.sv
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/100ps
module opm_sync2 #(
   parameter int W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   // ==========================================================
   // first stage read only by the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// ===== hw/opm_top.sv
// option port read mux with axi4-lite register access
// What this block does
// - op-amp option routes port pins to the amplifier instead of plain io
// - both comparator options without op-amp give two comparators on assigned pins
// - each comparator enabled alone by its own option; comparator two only without op-amp
// - comparator one on with bit1 read-zero set: bit 1 reads 0
// - comparator one on with bit1 read-zero clear: bit 1 reads pin
// - bit3 read-zero acts on bit 3 with comparator two likewise
// - comparator one on: bit 0 reads comparator one output
// - comparator two on: bit 2 reads comparator two output
// - all options clear: ordinary io port behaviour on every bit
// - op-amp plus comparator one, with comparator two clear, selects comparator-plus-op-amp mode
// - comparator-plus-op-amp mode: bits 2 and 3 read 0
// - comparator-plus-op-amp: bit 1 pin or 0, bit 0 comparator one
// - per-bit wake enables for ports a, b, d, e gate halt wake
// - audio dac selected: no pwm wake function
// - direction bit 1 output, 0 input; resets to all inputs
`timescale 1ns/100ps
module opm_top
   import opm_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // factory options, static straps
   input wire logic opamp_option,
   input wire logic comparator_one_enable_option,
   input wire logic comparator_two_enable_option,
   input wire logic bit1_read_zero_option,
   input wire logic bit3_read_zero_option,
   input wire logic audio_dac_select,
   input wire logic [3:0] port_a_wake_enable,
   input wire logic [3:0] port_b_wake_enable,
   input wire logic [3:0] port_d_wake_enable,
   input wire logic [3:0] port_e_wake_enable,
   // pins and analog front end
   input wire logic [3:0] combined_port_pin_in,
   output logic [3:0] combined_port_pin_out,
   output logic [3:0] combined_port_pin_oe,
   input wire logic comparator_one_out,
   input wire logic comparator_two_out,
   output logic opamp_enable,
   output logic comparator_one_enable,
   output logic comparator_two_enable,
   // wake sources and request
   input wire logic [3:0] port_a_pin,
   input wire logic [3:0] port_b_pin,
   input wire logic [3:0] port_d_pin,
   input wire logic [3:0] port_e_pin,
   input wire logic pwm_wake_event,
   input wire logic halted,
   output logic wake_request
);
   // ==========================================================
   // declarations
   logic captured;
   logic op_o, c1_o, c2_o, bit1_read_zero_option_o, bit3_read_zero_option_o, dac_o;
   logic [15:0] wake_en;
   opm_mode_t mode;
   logic [3:0] combined_port_direction;
   logic [3:0] combined_port_data;
   logic [3:0] port_read;
   logic [3:0] pin_s;
   logic [1:0] cmp_s;
   logic [15:0] wk_pins, wk_prev;
   logic [15:0] wake_seen;
   logic pwm_s, pwm_prev, pwm_seen;
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [31:0] next_rdata;
   logic next_rerr;
   logic do_write;
   // ==========================================================
   // pin synchronisers
   opm_sync2 #(.W(4)) u_pin_sync (
      .aclk(aclk), .aresetn(aresetn), .d(combined_port_pin_in), .q(pin_s));
   opm_sync2 #(.W(2)) u_cmp_sync (
      .aclk(aclk), .aresetn(aresetn),
      .d({comparator_two_out, comparator_one_out}), .q(cmp_s));
   opm_sync2 #(.W(16)) u_wake_sync (
      .aclk(aclk), .aresetn(aresetn),
      .d({port_e_pin, port_d_pin, port_b_pin, port_a_pin}), .q(wk_pins));
   opm_sync2 #(.W(1)) u_pwm_sync (
      .aclk(aclk), .aresetn(aresetn), .d(pwm_wake_event), .q(pwm_s));
   // ==========================================================
   // option capture once after reset release
   // latch options once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         captured <= 1'b0;
         op_o <= 1'b0;
         c1_o <= 1'b0;
         c2_o <= 1'b0;
         bit1_read_zero_option_o <= 1'b0;
         bit3_read_zero_option_o <= 1'b0;
         dac_o <= 1'b0;
         wake_en <= '0;
      end else if (!captured) begin
         captured <= 1'b1;
         op_o <= opamp_option;
         c1_o <= comparator_one_enable_option;
         c2_o <= comparator_two_enable_option;
         bit1_read_zero_option_o <= bit1_read_zero_option;
         bit3_read_zero_option_o <= bit3_read_zero_option;
         dac_o <= audio_dac_select;
         wake_en <= {port_e_wake_enable, port_d_wake_enable,
                     port_b_wake_enable, port_a_wake_enable};
      end
   end
   // ==========================================================
   // mode decode
   // op-amp and comparator one
   always_comb begin
      if (op_o && c1_o && !c2_o) mode = OPM_CMPOP;
      else if (op_o && (c1_o || c2_o)) mode = OPM_BAD;
      else if (op_o) mode = OPM_OPAMP;
      else if (c1_o || c2_o) mode = OPM_CMP;
      else mode = OPM_IO;
   end
   // ==========================================================
   // data read selection
   always_comb begin
      port_read = combined_port_data;
      for (int i = 0; i < OPM_PW; i++) begin
         if (!combined_port_direction[i]) port_read[i] = pin_s[i];
      end
      case (mode)
         OPM_IO, OPM_OPAMP: begin
         end
         OPM_CMP: begin
            if (c1_o) begin
               port_read[0] = cmp_s[0];
               port_read[1] = bit1_read_zero_option_o ? 1'b0 : pin_s[1];
            end
            if (c2_o) begin
               port_read[2] = cmp_s[1];
               port_read[3] = bit3_read_zero_option_o ? 1'b0 : pin_s[3];
            end
         end
         OPM_CMPOP: begin
            port_read[0] = cmp_s[0];
            port_read[1] = bit1_read_zero_option_o ? 1'b0 : pin_s[1];
            port_read[3:2] = 2'b00;
         end
         default: begin
            port_read = OPM_ZERO4;
         end
      endcase
   end
   // ==========================================================
   // analog enables and pin drive
   // route pins to analog blocks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opamp_enable <= 1'b0;
         comparator_one_enable <= 1'b0;
         comparator_two_enable <= 1'b0;
         combined_port_pin_out <= OPM_ZERO4;
         combined_port_pin_oe <= OPM_ZERO4;
      end else begin
         opamp_enable <= op_o && (mode != OPM_BAD);
         comparator_one_enable <= c1_o && (mode != OPM_BAD);
         comparator_two_enable <= c2_o && (mode == OPM_CMP);
         combined_port_pin_out <= combined_port_data;
         combined_port_pin_oe <= (mode == OPM_IO) ? combined_port_direction : OPM_ZERO4;
      end
   end
   // ==========================================================
   // wake detection: rising edges on enabled bits set sticky status; the wake request fires only while halted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wk_prev <= '0;
         pwm_prev <= 1'b0;
         wake_seen <= '0;
         pwm_seen <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         wk_prev <= wk_pins;
         pwm_prev <= pwm_s;
         // enabled bits only; set beats clear
         wake_seen <= (wake_seen & ~((do_write && aw_addr == OPM_WSTAT_OFS)
                       ? w_data[15:0] : 16'h0000)) | (wk_pins & ~wk_prev & wake_en);
         pwm_seen <= (pwm_seen & ~(do_write && aw_addr == OPM_WSTAT_OFS
                      && w_data[OPM_WK_PWM])) | (pwm_s & ~pwm_prev & ~dac_o);
         wake_request <= halted && (|(wk_pins & ~wk_prev & wake_en)
                         || (pwm_s && !pwm_prev && !dac_o));
      end
   end
   // ==========================================================
   // axi4-lite write path
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= OPM_RESP_OKAY;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         // ready flops follow the held and response state
         s_axi_awready <= !aw_held && !s_axi_bvalid;
         s_axi_wready <= !w_held && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == OPM_DIR_OFS || aw_addr == OPM_DATA_OFS
                            || aw_addr == OPM_WSTAT_OFS) ? OPM_RESP_OKAY : OPM_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end
   // port registers
   // direction reset to inputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         combined_port_direction <= OPM_DIR_RST;
         combined_port_data <= OPM_DATA_RST;
      end else if (do_write && w_strb[0]) begin
         if (aw_addr == OPM_DIR_OFS) combined_port_direction <= w_data[3:0];
         if (aw_addr == OPM_DATA_OFS) combined_port_data <= w_data[3:0];
      end
   end
   // ==========================================================
   // axi4-lite read path
   always_comb begin
      next_rdata = '0;
      next_rerr = 1'b0;
      case (s_axi_araddr)
         OPM_DIR_OFS: next_rdata[3:0] = combined_port_direction;
         OPM_DATA_OFS: next_rdata[3:0] = port_read;
         OPM_OPT_OFS: next_rdata = {19'h0, mode, 2'h0, dac_o, bit3_read_zero_option_o, bit1_read_zero_option_o,
                                    c2_o, c1_o, op_o};
         OPM_WAKE_OFS: next_rdata[15:0] = wake_en;
         OPM_WSTAT_OFS: next_rdata = {15'h0, pwm_seen, wake_seen};
         default: next_rerr = 1'b1;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= OPM_RESP_OKAY;
         s_axi_arready <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rerr ? OPM_RESP_SLVERR : OPM_RESP_OKAY;
         s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else begin
         s_axi_arready <= !s_axi_rvalid;
      end
   end
   // ==========================================================
   // checks
   // upper bits zero
   AST_CMPOP_UPPER: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode == OPM_CMPOP) |-> port_read[3:2] == 2'b00)
      else $error("upper bits not zero in comparator op mode");
   AST_BIT1_READ_ZERO_OPTION: assert property (@(posedge aclk) disable iff (!aresetn)
      (c1_o && bit1_read_zero_option_o && mode != OPM_BAD) |-> !port_read[1])
      else $error("bit 1 not zero");
   AST_CMP1_BIT0: assert property (@(posedge aclk) disable iff (!aresetn)
      (c1_o && mode != OPM_BAD) |-> port_read[0] == cmp_s[0])
      else $error("bit 0 not comparator one");
   AST_CMP2_BIT2: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode == OPM_CMP && c2_o) |-> port_read[2] == cmp_s[1])
      else $error("bit 2 not comparator two");
   AST_OPT_STABLE: assert property (@(posedge aclk) disable iff (!aresetn)
      captured |=> $stable(op_o) && $stable(c1_o) && $stable(wake_en))
      else $error("option changed after capture");
   AST_OE_NON_IO: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode != OPM_IO) |=> combined_port_pin_oe == OPM_ZERO4)
      else $error("pin driven outside io mode");
endmodule

// ===== sim/opm_pins_model.sv
// model of the pins and analog comparators facing the option port
`timescale 1ns/100ps
module opm_pins_model (
   input wire logic aclk,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   input wire logic [3:0] ext_level,
   input wire logic cmp1_on,
   input wire logic cmp2_on,
   input wire logic cmp1_level,
   input wire logic cmp2_level,
   output logic [3:0] pin_level,
   output logic cmp1_out,
   output logic cmp2_out
);
   // ==========================================================
   // idle pattern, changes every cycle
   logic toggle = 1'b0;
   always @(posedge aclk) begin
      toggle <= ~toggle;
   end
   // a driven pin shows the port level, else the outside world
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
   // a switched-off comparator gives no stable answer
   assign cmp1_out = cmp1_on ? cmp1_level : toggle;
   assign cmp2_out = cmp2_on ? cmp2_level : ~toggle;
endmodule

// ===== sim/opm_top_test.sv
// self-checking bench of the option port read mux
`timescale 1ns/100ps
module opm_top_test;
   import opm_pkg::*;
   // ==========================================================
   // stimulus and observed signals
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid, wake;
   logic [1:0] bresp, rresp;
   logic [5:0] opt = 6'h00;
   logic [3:0] wen_a = 4'h0, wen_e = 4'h0, pa = 4'h0, pb = 4'h0, ext = 4'h0;
   logic [3:0] wstrb = 4'hF;
   logic [3:0] pin_in, pin_out, pin_oe;
   logic k1 = 1'b0, k2 = 1'b0, pwm = 1'b0, halted = 1'b0;
   logic c1_out, c2_out, op_en, c1_en, c2_en;
   int fails = 0, compares = 0;
   always #25 aclk = ~aclk;
   // ==========================================================
   // device and far side
   opm_top opm_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .opamp_option(opt[0]), .comparator_one_enable_option(opt[1]),
      .comparator_two_enable_option(opt[2]), .bit1_read_zero_option(opt[3]),
      .bit3_read_zero_option(opt[4]), .audio_dac_select(opt[5]),
      .port_a_wake_enable(wen_a), .port_b_wake_enable(4'h0), .port_d_wake_enable(4'h0),
      .port_e_wake_enable(wen_e), .combined_port_pin_in(pin_in),
      .combined_port_pin_out(pin_out), .combined_port_pin_oe(pin_oe),
      .comparator_one_out(c1_out), .comparator_two_out(c2_out), .opamp_enable(op_en),
      .comparator_one_enable(c1_en), .comparator_two_enable(c2_en), .port_a_pin(pa),
      .port_b_pin(pb), .port_d_pin(4'h0), .port_e_pin(4'h0), .pwm_wake_event(pwm),
      .halted(halted), .wake_request(wake));
   opm_pins_model opm_pins_model_i (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .ext_level(ext), .cmp1_on(c1_en), .cmp2_on(c2_en), .cmp1_level(k1), .cmp2_level(k2),
      .pin_level(pin_in), .cmp1_out(c1_out), .cmp2_out(c2_out));
   // ==========================================================
   // verdict and comparison
   task results();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // ==========================================================
   // axi4-lite master cycles, each bounded
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      rs = 2'h3;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            rs = bresp; bready <= 1'b0; break;
         end
      end
      if (n == 40) begin fails++; results(); end
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      d = 32'h0; rs = 2'h3;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata; rs = rresp; rready <= 1'b0; break;
         end
      end
      if (n == 40) begin fails++; results(); end
   endtask
   // reset with a new strap set, then check option readback
   task setup(input logic [5:0] o, input logic [4:0] mode);
      logic [31:0] r;
      logic [1:0] rs;
      @(posedge aclk);
      opt <= o; aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(OPM_OPT_OFS, r, rs);
      chk("opt", r[5:0], o);
      chk("mode", r[12:8], mode);
      chk("enables", {c2_en, c1_en, op_en}, o[2:0]);
   endtask
   // expected data read for inputs only
   function automatic logic [3:0] exp_rd(input logic [5:0] o, input logic [3:0] p,
      input logic a, input logic b);
      logic [3:0] e;
      e = p;
      if (o[1]) begin e[0] = a; e[1] = o[3] ? 1'b0 : p[1]; end
      if (o[2]) begin e[2] = b; e[3] = o[4] ? 1'b0 : p[3]; end
      if (o[0] && o[1]) e[3:2] = 2'b00;
      return e;
   endfunction
   // ==========================================================
   // scenarios
   task t_io();
      logic [31:0] r;
      logic [1:0] rs;
      setup(6'h00, OPM_IO);
      rd(OPM_DIR_OFS, r, rs);
      chk("dir reset", r[3:0], 4'h0);
      wr(OPM_DIR_OFS, 32'h0000000F, rs);
      chk("bresp", rs, OPM_RESP_OKAY);
      wr(OPM_DATA_OFS, 32'h00000005, rs);
      repeat (2) @(posedge aclk);
      chk("oe", pin_oe, 4'hF);
      chk("pin out", pin_out, 4'h5);
      rd(OPM_DATA_OFS, r, rs);
      chk("latch", r[3:0], 4'h5);
      wr(OPM_DIR_OFS, 32'h00000000, rs);
      ext <= 4'hA;
      repeat (4) @(posedge aclk);
      rd(OPM_DATA_OFS, r, rs);
      chk("pins", r[3:0], 4'hA);
      $display("test io done");
   endtask
   task t_comparators();
      automatic logic [5:0] cf [8] = '{6'h02, 6'h0A, 6'h04, 6'h14, 6'h0E, 6'h16, 6'h03, 6'h0B};
      logic [31:0] r;
      logic [1:0] rs;
      logic [3:0] e;
      for (int i = 0; i < 8; i++) begin
         // op-amp with comparator two never strapped
         setup(cf[i], cf[i][0] ? OPM_CMPOP : OPM_CMP);
         for (int j = 0; j < 2; j++) begin
            ext <= j ? 4'hA : 4'h5; k1 <= j[0]; k2 <= ~j[0];
            repeat (4) @(posedge aclk);
            rd(OPM_DATA_OFS, r, rs);
            e = exp_rd(cf[i], ext, k1, k2);
            chk("cmp data", r[3:0], e);
         end
      end
      $display("test comparators done");
   endtask
   task t_opamp();
      logic [31:0] r;
      logic [1:0] rs;
      setup(6'h01, OPM_OPAMP);
      // bit 1 stays an input while the amplifier owns the pins
      wr(OPM_DIR_OFS, 32'h0000000D, rs);
      repeat (2) @(posedge aclk);
      chk("oe opamp", pin_oe, 4'h0);
      rd(OPM_DIR_OFS, r, rs);
      chk("dir opamp", r[3:0], 4'hD);
      $display("test opamp done");
   endtask
   task t_wake();
      logic [31:0] r;
      logic [1:0] rs;
      int c;
      wen_a <= 4'h1; wen_e <= 4'h8;
      setup(6'h20, OPM_IO);
      rd(OPM_WAKE_OFS, r, rs);
      chk("wake enables", r[15:0], 16'h8001);
      halted <= 1'b1;
      for (int s = 0; s < 3; s++) begin
         @(posedge aclk);
         if (s == 0) pb <= 4'h1;
         if (s == 1) pwm <= 1'b1;
         if (s == 2) pa <= 4'h1;
         c = 0;
         repeat (10) begin
            @(posedge aclk);
            if (wake === 1'b1) c++;
         end
         chk("wake count", c, s == 2);
      end
      halted <= 1'b0; pa <= 4'h0; pb <= 4'h0; pwm <= 1'b0;
      // sticky status: only the enabled port a edge, no pwm edge with dac
      rd(OPM_WSTAT_OFS, r, rs);
      chk("wake status", r, 32'h00000001);
      wr(OPM_WSTAT_OFS, 32'h00010001, rs);
      rd(OPM_WSTAT_OFS, r, rs);
      chk("wake clear", r, 32'h00000000);
      $display("test wake done");
   endtask
   task t_bus();
      logic [31:0] r;
      logic [1:0] rs;
      rd(8'h3C, r, rs);
      chk("unmapped resp", rs, OPM_RESP_SLVERR);
      chk("unmapped data", r, 32'h0);
      wr(OPM_OPT_OFS, 32'h0000003F, rs);
      chk("option write", rs, OPM_RESP_SLVERR);
      rd(OPM_OPT_OFS, r, rs);
      chk("opt held", r[5:0], 6'h20);
      // a write without the low byte strobe leaves direction alone
      wstrb <= 4'h0;
      wr(OPM_DIR_OFS, 32'h0000000F, rs);
      wstrb <= 4'hF;
      rd(OPM_DIR_OFS, r, rs);
      chk("strobe off", r[3:0], 4'h0);
      $display("test bus done");
   endtask
   // ==========================================================
   // main sequence
   initial begin
      t_io();
      t_comparators();
      t_opamp();
      t_wake();
      t_bus();
      results();
   end
endmodule
